// file: design/sdr_pkg.sv
// Purpose: Shared constants and types of the serial-port register block.
// Assumes: Byte addresses on an 8-bit register port, one 32-bit word each.
// Notes:   Field positions are shared by the status and mask words.
package sdr_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_RDR  = 8'h08;
   localparam logic [7:0] OFS_TDR  = 8'h0C;
   localparam logic [7:0] OFS_SR   = 8'h10;
   localparam logic [7:0] OFS_IER  = 8'h14;
   localparam logic [7:0] OFS_IDR  = 8'h18;
   localparam logic [7:0] OFS_IMR  = 8'h1C;
   localparam logic [7:0] OFS_CSR0 = 8'h30;
   localparam logic [7:0] OFS_CSR3 = 8'h3C;
   // ==========================================================
   // Control, mode and data fields
   localparam int CTRL_EN  = 0;
   localparam int CTRL_DIS = 1;
   localparam int MODE_MST = 0;
   localparam int MODE_VAR = 1;
   localparam int MODE_DEC = 2;
   localparam int SEL_LSB  = 16;
   localparam int FINAL_B  = 24;
   // ==========================================================
   // Select configuration fields
   localparam int CFG_BCT  = 24;
   localparam int CFG_BS   = 16;
   localparam int CFG_BAUD = 8;
   localparam int CFG_BITS = 4;
   localparam int CFG_HOLD = 3;
   localparam int CFG_PHA  = 1;
   localparam int CFG_POL  = 0;
   localparam logic [3:0] BITS_MAX  = 4'h8;
   localparam logic [4:0] BITS_BASE = 5'h08;
   localparam logic [3:0] SEL_NONE  = 4'hF;
   localparam int NUM_SRC  = 10;
   localparam int SR_ENS   = 16;
   localparam int DLY_UNIT = 32;
   // ==========================================================
   // State
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DELAY} sdr_state_e;
   typedef struct packed {
      sdr_state_e       st;
      logic             enabled;
      logic             master;
      logic             var_sel;
      logic             sel_dec;
      logic [3:0]       fixed_sel;
      logic [9:0]       imr;
      logic [3:0][31:0] csr;
      logic [15:0]      rx_data;
      logic [3:0]       rx_sel;
      logic [15:0]      tx_char;
      logic [3:0]       tx_sel;
      logic             tx_final;
      logic             tx_pending;
      logic [9:0]       flg;
      logic             ss_meta;
      logic             ss_sync;
      logic             ss_prev;
      logic             rxz_prev;
      logic             txz_prev;
      logic [3:0]       sel_lines;
      logic             cur_final;
      logic             cur_hold;
      logic [7:0]       cur_bct;
      logic [12:0]      dly;
      logic             tx_load;
      logic [15:0]      tx_out;
      logic [4:0]       bits;
      logic [7:0]       baud;
      logic [7:0]       pre_dly;
      logic             pha;
      logic             pol;
      logic             irq;
      logic [31:0]      rdata;
   } sdr_regs_s;
endpackage

// file: design/sdr_regs.sv
// Purpose: Software register block of a serial peripheral controller.
// Assumes: Shift engine and DMA counters sit outside on CLK_I.
// Notes:   Register reads answer in the cycle after the read strobe.
`timescale 1ns/1ns
module sdr_regs #(
   parameter int DELAY_UNIT = sdr_pkg::DLY_UNIT
) (
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   // Register port
   input  wire logic [7:0]  ADDR_I,
   input  wire logic [31:0] WDATA_I,
   input  wire logic        WE_I,
   input  wire logic        RE_I,
   output logic      [31:0] RDATA_O,
   // Pin
   input  wire logic        SLAVE_SELECT_IN_I,
   // Shift engine
   input  wire logic        SHIFT_BUSY_I,
   input  wire logic        SHIFT_DONE_I,
   input  wire logic [15:0] RX_CHAR_I,
   input  wire logic        MODE_FAULT_I,
   output logic             TX_LOAD_O,
   output logic      [15:0] TX_CHAR_O,
   output logic      [3:0]  SELECT_LINES_O,
   output logic      [4:0]  CHAR_BITS_O,
   output logic      [7:0]  BAUD_DIVISOR_O,
   output logic      [7:0]  PRE_CLOCK_DELAY_O,
   output logic             CLOCK_PHASE_O,
   output logic             CLOCK_POLARITY_O,
   output logic             MASTER_O,
   output logic             ENABLED_O,
   // DMA counters
   input  wire logic        RX_DMA_ZERO_I,
   input  wire logic        RX_DMA_NEXT_ZERO_I,
   input  wire logic        RX_DMA_WR_I,
   input  wire logic        TX_DMA_ZERO_I,
   input  wire logic        TX_DMA_NEXT_ZERO_I,
   input  wire logic        TX_DMA_WR_I,
   // Interrupt
   output logic             IRQ_O
);

   // ==========================================================
   // Functions

   function automatic logic [3:0] sel_decode(
      input logic [3:0] v,
      input logic       dec
   );
      logic [3:0] o;
      o = sdr_pkg::SEL_NONE;
      if (dec) begin
         o = v;
      end else begin
         for (int i = 3; i >= 0; i--) begin
            if (!v[i]) begin
               o = ~(4'h1 << i);
            end
         end
      end
      return o;
   endfunction

   function automatic logic [1:0] sel_index(
      input logic [3:0] v,
      input logic       dec
   );
      logic [1:0] o;
      o = 2'h3;
      if (dec) begin
         o = v[3:2];
      end else begin
         for (int i = 3; i >= 0; i--) begin
            if (!v[i]) begin
               o = 2'(i);
            end
         end
      end
      return o;
   endfunction

   // Reserved lengths are clamped to the longest legal one.
   function automatic logic [4:0] char_len(input logic [3:0] b);
      logic [3:0] c;
      c = (b > sdr_pkg::BITS_MAX) ? sdr_pkg::BITS_MAX : b;
      return sdr_pkg::BITS_BASE + {1'b0, c};
   endfunction

   function automatic logic [15:0] len_mask(input logic [4:0] n);
      logic [16:0] m;
      m = (17'h1 << n) - 17'h1;
      return m[15:0];
   endfunction

   // ==========================================================
   // State

   sdr_pkg::sdr_regs_s r;
   sdr_pkg::sdr_regs_s n;

   logic [3:0]  sel;
   logic [1:0]  idx;
   logic [31:0] cfg;
   logic        rdr_rd;
   logic        sr_rd;
   logic        tdr_wr;
   logic        csr_hit;
   logic [1:0]  csr_idx;
   logic [31:0] sr_word;
   logic [7:0]  csr_ofs;

   always_comb begin
      n       = r;
      sel     = r.var_sel ? r.tx_sel : r.fixed_sel;
      idx     = sel_index(sel, r.sel_dec);
      cfg     = r.csr[idx];
      rdr_rd  = RE_I && (ADDR_I == sdr_pkg::OFS_RDR);
      sr_rd   = RE_I && (ADDR_I == sdr_pkg::OFS_SR);
      tdr_wr  = WE_I && (ADDR_I == sdr_pkg::OFS_TDR);
      csr_ofs = ADDR_I - sdr_pkg::OFS_CSR0;
      csr_hit = (ADDR_I >= sdr_pkg::OFS_CSR0) && (ADDR_I <= sdr_pkg::OFS_CSR3)
                && (ADDR_I[1:0] == 2'h0);
      csr_idx = csr_ofs[3:2];
      n.tx_load = 1'b0;
      n.rdata   = 32'h0;

      // Only the second and third stages of the pin chain are examined.
      n.ss_meta  = SLAVE_SELECT_IN_I;
      n.ss_sync  = r.ss_meta;
      n.ss_prev  = r.ss_sync;
      n.rxz_prev = RX_DMA_ZERO_I;
      n.txz_prev = TX_DMA_ZERO_I;

      // Clears come first so that a set in the same cycle wins.
      if (rdr_rd) begin
         n.flg[0] = 1'b0;
      end
      if (sr_rd) begin
         n.flg[2] = 1'b0;
         n.flg[3] = 1'b0;
         n.flg[8] = 1'b0;
      end
      if (RX_DMA_WR_I) begin
         n.flg[4] = 1'b0;
      end
      if (TX_DMA_WR_I) begin
         n.flg[5] = 1'b0;
      end

      // ========================================================
      // Register writes
      if (WE_I) begin
         case (ADDR_I)
            sdr_pkg::OFS_CTRL: begin
               if (WDATA_I[sdr_pkg::CTRL_EN]) begin
                  n.enabled = 1'b1;
                  n.flg[1]  = 1'b1;
               end
               if (WDATA_I[sdr_pkg::CTRL_DIS]) begin
                  n.enabled = 1'b0;
                  n.flg[1]  = 1'b0;
               end
            end
            sdr_pkg::OFS_MODE: begin
               n.master    = WDATA_I[sdr_pkg::MODE_MST];
               n.var_sel   = WDATA_I[sdr_pkg::MODE_VAR];
               n.sel_dec   = WDATA_I[sdr_pkg::MODE_DEC];
               n.fixed_sel = WDATA_I[sdr_pkg::SEL_LSB +: 4];
            end
            sdr_pkg::OFS_TDR: begin
               n.tx_char    = WDATA_I[15:0];
               n.tx_sel     = WDATA_I[sdr_pkg::SEL_LSB +: 4];
               n.tx_final   = WDATA_I[sdr_pkg::FINAL_B];
               n.tx_pending = 1'b1;
               n.flg[1]     = 1'b0;
               n.flg[9]     = 1'b0;
            end
            sdr_pkg::OFS_IER: begin
               n.imr = r.imr | WDATA_I[sdr_pkg::NUM_SRC-1:0];
            end
            sdr_pkg::OFS_IDR: begin
               n.imr = r.imr & ~WDATA_I[sdr_pkg::NUM_SRC-1:0];
            end
            default: begin
               if (csr_hit) begin
                  n.csr[csr_idx] = WDATA_I;
               end
            end
         endcase
      end

      // ========================================================
      // Hardware events
      if (MODE_FAULT_I) begin
         n.flg[2] = 1'b1;
      end
      if (r.ss_sync && !r.ss_prev) begin
         n.flg[8] = 1'b1;
      end
      if (RX_DMA_ZERO_I && !r.rxz_prev) begin
         n.flg[4] = 1'b1;
      end
      if (TX_DMA_ZERO_I && !r.txz_prev) begin
         n.flg[5] = 1'b1;
      end
      n.flg[6] = RX_DMA_ZERO_I && RX_DMA_NEXT_ZERO_I;
      n.flg[7] = TX_DMA_ZERO_I && TX_DMA_NEXT_ZERO_I;
      if (SHIFT_DONE_I) begin
         if (r.flg[0] && !rdr_rd) begin
            n.flg[3] = 1'b1;
         end
         n.flg[0]   = 1'b1;
         n.rx_data  = RX_CHAR_I & len_mask(r.bits);
         n.rx_sel   = r.master ? r.sel_lines : 4'h0;
      end

      // ========================================================
      // Transfer sequencing
      case (r.st)
         sdr_pkg::ST_IDLE: begin
            // A data register write in this cycle defers the handoff by one cycle.
            // The enable seen here includes a control write in this cycle, so a disable never meets a load.
            if (n.enabled && r.tx_pending && !tdr_wr && !SHIFT_BUSY_I) begin
               n.tx_load    = 1'b1;
               n.tx_out     = r.tx_char;
               n.tx_pending = 1'b0;
               n.flg[1]     = 1'b1;
               n.sel_lines  = sel_decode(sel, r.sel_dec);
               n.cur_final  = r.var_sel && r.tx_final;
               n.cur_hold   = cfg[sdr_pkg::CFG_HOLD];
               n.cur_bct    = cfg[sdr_pkg::CFG_BCT +: 8];
               n.bits       = char_len(cfg[sdr_pkg::CFG_BITS +: 4]);
               n.baud       = cfg[sdr_pkg::CFG_BAUD +: 8];
               n.pre_dly    = cfg[sdr_pkg::CFG_BS +: 8];
               n.pha        = cfg[sdr_pkg::CFG_PHA];
               n.pol        = cfg[sdr_pkg::CFG_POL];
               n.st         = sdr_pkg::ST_SHIFT;
            end else if (n.enabled && !r.tx_pending && !tdr_wr && !SHIFT_BUSY_I) begin
               n.flg[9] = 1'b1;
            end
         end
         sdr_pkg::ST_SHIFT: begin
            if (SHIFT_DONE_I) begin
               n.dly = 13'(r.cur_bct * DELAY_UNIT);
               n.st  = sdr_pkg::ST_DELAY;
            end
         end
         sdr_pkg::ST_DELAY: begin
            if (r.dly != 13'h0) begin
               n.dly = r.dly - 13'h1;
            end else begin
               if (r.cur_final || !r.cur_hold) begin
                  n.sel_lines = sdr_pkg::SEL_NONE;
               end
               n.st = sdr_pkg::ST_IDLE;
            end
         end
         default: begin
            n.st = sdr_pkg::ST_IDLE;
         end
      endcase
      if (!n.enabled) begin
         n.flg[1] = 1'b0;
         n.flg[9] = 1'b0;
      end

      // ========================================================
      // Status word, interrupt and read data
      sr_word = 32'h0;
      sr_word[sdr_pkg::NUM_SRC-1:0] = r.flg;
      sr_word[sdr_pkg::SR_ENS] = r.enabled;
      n.irq = |(n.flg & n.imr);
      if (RE_I) begin
         case (ADDR_I)
            sdr_pkg::OFS_MODE: begin
               n.rdata[sdr_pkg::MODE_MST] = r.master;
               n.rdata[sdr_pkg::MODE_VAR] = r.var_sel;
               n.rdata[sdr_pkg::MODE_DEC] = r.sel_dec;
               n.rdata[sdr_pkg::SEL_LSB +: 4] = r.fixed_sel;
            end
            sdr_pkg::OFS_RDR: begin
               n.rdata[15:0] = r.rx_data;
               n.rdata[sdr_pkg::SEL_LSB +: 4] = r.rx_sel;
            end
            sdr_pkg::OFS_SR: begin
               n.rdata = sr_word;
            end
            sdr_pkg::OFS_IMR: begin
               n.rdata[sdr_pkg::NUM_SRC-1:0] = r.imr;
            end
            default: begin
               if (csr_hit) begin
                  n.rdata = r.csr[csr_idx];
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Registers

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         r           <= '0;
         r.st        <= sdr_pkg::ST_IDLE;
         r.sel_lines <= sdr_pkg::SEL_NONE;
         r.flg[4]    <= 1'b1;
         r.flg[5]    <= 1'b1;
         r.flg[6]    <= 1'b1;
         r.flg[7]    <= 1'b1;
         r.bits      <= sdr_pkg::BITS_BASE;
         r.ss_meta   <= 1'b1;
         r.ss_sync   <= 1'b1;
         r.ss_prev   <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ==========================================================
   // Outputs

   assign RDATA_O           = r.rdata;
   assign TX_LOAD_O         = r.tx_load;
   assign TX_CHAR_O         = r.tx_out;
   assign SELECT_LINES_O    = r.sel_lines;
   assign CHAR_BITS_O       = r.bits;
   assign BAUD_DIVISOR_O    = r.baud;
   assign PRE_CLOCK_DELAY_O = r.pre_dly;
   assign CLOCK_PHASE_O     = r.pha;
   assign CLOCK_POLARITY_O  = r.pol;
   assign MASTER_O          = r.master;
   assign ENABLED_O         = r.enabled;
   assign IRQ_O             = r.irq;

endmodule

// file: dv/sdr_regs_chk.sv
// Purpose: Port-level assertions for the serial-port register block.
// Assumes: One clock domain; read data stands in the cycle after the strobe.
// Notes:   Clear-on-read checks skip cycles where a set event lands.
`timescale 1ns/1ns
module sdr_regs_chk (
   // Clock, reset and register port
   input wire logic        CLK_I,
   input wire logic        RST_I,
   input wire logic [7:0]  ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic        WE_I,
   input wire logic        RE_I,
   input wire logic [31:0] RDATA_O,
   // Engine, status and counter levels
   input wire logic        SHIFT_DONE_I,
   input wire logic        MODE_FAULT_I,
   input wire logic        TX_LOAD_O,
   input wire logic        ENABLED_O,
   input wire logic        RX_DMA_ZERO_I,
   input wire logic        RX_DMA_NEXT_ZERO_I
);
   wire rd_sr  = RE_I && ADDR_I == sdr_pkg::OFS_SR;
   wire rd_rx  = RE_I && ADDR_I == sdr_pkg::OFS_RDR;
   wire rd_imr = RE_I && ADDR_I == sdr_pkg::OFS_IMR;
   wire quiet  = !SHIFT_DONE_I && !MODE_FAULT_I;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // ==========================================================
   // Register reads
   property p_rx_upper; rd_rx |=> RDATA_O[31:20] == 12'h000; endproperty
   a_rx_upper: assert property (p_rx_upper) else $error("receive word upper bits not zero");
   property p_mask_set; WE_I && ADDR_I == sdr_pkg::OFS_IER ##1 rd_imr |=> (~RDATA_O[9:0] & $past(WDATA_I[9:0], 2)) == 10'h0; endproperty
   a_mask_set: assert property (p_mask_set) else $error("enabled source missing from mask");
   property p_mask_clr; WE_I && ADDR_I == sdr_pkg::OFS_IDR ##1 rd_imr |=> (RDATA_O[9:0] & $past(WDATA_I[9:0], 2)) == 10'h0; endproperty
   a_mask_clr: assert property (p_mask_clr) else $error("disabled source still in mask");
   property p_mask_hi; rd_imr |=> RDATA_O[31:10] == 22'h0; endproperty
   a_mask_hi: assert property (p_mask_hi) else $error("mask word has bits above the sources");
   property p_sr_clear; rd_sr && quiet ##1 rd_sr && quiet |=> RDATA_O[3:2] == 2'b00; endproperty
   a_sr_clear: assert property (p_sr_clear) else $error("fault or overrun survived a status read");
   property p_rx_clear; rd_rx && quiet ##1 rd_sr && quiet |=> !RDATA_O[0]; endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("receive full survived a data read");
   property p_dma_buf; rd_sr && $stable(RX_DMA_ZERO_I) && $stable(RX_DMA_NEXT_ZERO_I) |=> RDATA_O[6] == $past(RX_DMA_ZERO_I && RX_DMA_NEXT_ZERO_I); endproperty
   a_dma_buf: assert property (p_dma_buf) else $error("receive buffer flag off its counters");
   // ==========================================================
   // Transmit handoff
   property p_tdr_wait; WE_I && ADDR_I == sdr_pkg::OFS_TDR |=> !TX_LOAD_O; endproperty
   a_tdr_wait: assert property (p_tdr_wait) else $error("load in the cycle after a data write");
   property p_load_pulse; TX_LOAD_O |-> ENABLED_O ##1 !TX_LOAD_O; endproperty
   a_load_pulse: assert property (p_load_pulse) else $error("load while disabled or too long");
endmodule
bind sdr_regs sdr_regs_chk u_sdr_regs_chk (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
   .WE_I(WE_I), .RE_I(RE_I), .RDATA_O(RDATA_O), .SHIFT_DONE_I(SHIFT_DONE_I), .MODE_FAULT_I(MODE_FAULT_I),
   .TX_LOAD_O(TX_LOAD_O), .ENABLED_O(ENABLED_O), .RX_DMA_ZERO_I(RX_DMA_ZERO_I),
   .RX_DMA_NEXT_ZERO_I(RX_DMA_NEXT_ZERO_I));

// file: dv/sdr_shift_model.sv
// Purpose: Behavioural shift engine that loops each sent character back.
// Assumes: A load pulse carries the character on the same cycle.
// Notes:   Received data is only meaningful with the done pulse.
`timescale 1ns/1ns
module sdr_shift_model (
   // Clock and control
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        load_i,
   input  wire logic        slow_i,
   input  wire logic [15:0] char_i,
   // Engine answers
   output logic             busy_o,
   output logic             done_o,
   output logic      [15:0] rx_o
);
   int          cnt;
   logic [15:0] held;
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         cnt    <= 0;
         rx_o   <= 16'h0000;
      end else begin
         done_o <= 1'b0;
         // Churn the data outside done so a stale sample cannot match.
         rx_o   <= rx_o + 16'h1357;
         if (load_i) begin
            busy_o <= 1'b1;
            cnt    <= slow_i ? 12 : 2;
            held   <= char_i;
         end else if (busy_o && cnt == 1) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
            rx_o   <= held;
         end else if (busy_o) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule

// file: dv/sdr_regs_tb_top.sv
// Purpose: Self-checking bench for the serial-port register block.
// Assumes: The engine model echoes the sent character.
// Notes:   Read expectations queue as mask and value pairs.
`timescale 1ns/1ns
module sdr_regs_tb_top;
   logic        CLK_I = 0;
   logic        RST_I = 1;
   logic [7:0]  ADDR_I = 8'h00;
   logic [31:0] WDATA_I = 32'h0;
   logic        WE_I = 0;
   logic        RE_I = 0;
   logic        SLAVE_SELECT_IN_I = 0;
   logic        MODE_FAULT_I = 0;
   logic        slow = 0;
   logic [3:0]  dz = 4'hF;
   logic [1:0]  dw = 2'h0;
   wire         shift_busy, shift_done, tx_load, irq;
   wire  [15:0] rx_char, tx_char;
   wire  [31:0] rdata;
   wire  [3:0]  lines;
   wire  [4:0]  bits_o;
   wire  [7:0]  baud_o, pre_o;
   wire         pha_o, pol_o, master_o, en_o;
   logic [4:0]  eb = 5'h08;
   integer      bad_count = 0, n_checks = 0, cyc = 0, seed = 19035;
   logic        re_prev = 0;
   logic [63:0] rq[$];
   logic [24:0] tq[$];
   logic [15:0] ch;
   logic [31:0] r, q;
   logic [3:0]  sel_tab [4] = '{4'hA, 4'h5, 4'hB, 4'h7};
   logic [3:0]  line_tab [4] = '{4'hE, 4'hD, 4'hB, 4'h7};
   always #5 CLK_I = ~CLK_I;
   sdr_regs #(.DELAY_UNIT(1)) u_sdr_regs (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
      .WE_I(WE_I), .RE_I(RE_I), .RDATA_O(rdata), .SLAVE_SELECT_IN_I(SLAVE_SELECT_IN_I),
      .SHIFT_BUSY_I(shift_busy), .SHIFT_DONE_I(shift_done), .RX_CHAR_I(rx_char), .MODE_FAULT_I(MODE_FAULT_I),
      .TX_LOAD_O(tx_load), .TX_CHAR_O(tx_char), .SELECT_LINES_O(lines), .CHAR_BITS_O(bits_o),
      .BAUD_DIVISOR_O(baud_o), .PRE_CLOCK_DELAY_O(pre_o), .CLOCK_PHASE_O(pha_o), .CLOCK_POLARITY_O(pol_o),
      .MASTER_O(master_o), .ENABLED_O(en_o),
      .RX_DMA_ZERO_I(dz[0]), .RX_DMA_NEXT_ZERO_I(dz[1]), .RX_DMA_WR_I(dw[0]), .TX_DMA_ZERO_I(dz[2]),
      .TX_DMA_NEXT_ZERO_I(dz[3]), .TX_DMA_WR_I(dw[1]), .IRQ_O(irq));
   sdr_shift_model u_sdr_shift_model (.clk_i(CLK_I), .rst_i(RST_I), .load_i(tx_load), .slow_i(slow),
      .char_i(tx_char), .busy_o(shift_busy), .done_o(shift_done), .rx_o(rx_char));
   // ==========================================================
   // Bus tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic rr, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_I);
      WE_I    <= w;
      RE_I    <= rr;
      ADDR_I  <= a;
      WDATA_I <= d;
   endtask
   task automatic nop(input int n);
      repeat (n) bus(1'b0, 1'b0, ADDR_I, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rq.push_back({m, e & m});
      bus(1'b0, 1'b1, a, 32'h0);
   endtask
   // Writes one character and waits, bounded, for the engine to finish.
   task automatic send(input logic [3:0] sel, input logic fin, input logic [3:0] ln);
      ch = 16'($random(seed));
      tq.push_back({eb, ln, ch});
      bus(1'b1, 1'b0, sdr_pkg::OFS_TDR, {7'h00, fin, 4'h0, sel, ch});
      for (int i = 0; i < 40; i++) begin
         nop(1);
         #1;
         if (shift_done) break;
      end
      nop(4);
      #1;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ==========================================================
   // Monitors
   always @(negedge CLK_I) begin
      if (re_prev) begin
         chk(rdata & rq[0][63:32], rq[0][31:0]);
         void'(rq.pop_front());
      end
      if (tx_load) begin
         chk({12'h000, lines, tx_char}, {12'h000, tq[0][19:0]});
         chk({8'h00, en_o, pha_o, pol_o, bits_o, baud_o, pre_o}, {8'h00, 3'b100, tq[0][24:20], 16'h0100});
         void'(tq.pop_front());
      end
      re_prev = RE_I;
   end
   always @(posedge CLK_I) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         tally_and_finish;
      end
   end
   // ==========================================================
   // Scenarios
   initial begin
      repeat (4) @(posedge CLK_I);
      RST_I <= 1'b0;
      rd(sdr_pkg::OFS_SR, 32'h0000_00F0, '1);
      rd(sdr_pkg::OFS_IMR, 32'h0, '1);
      rd(sdr_pkg::OFS_TDR, 32'h0, '1);
      rd(8'h20, 32'h0, '1);
      r = $random(seed);
      bus(1'b1, 1'b0, sdr_pkg::OFS_IER, r);
      rd(sdr_pkg::OFS_IMR, r & 32'h3FF, '1);
      q = $random(seed);
      bus(1'b1, 1'b0, sdr_pkg::OFS_IDR, q);
      rd(sdr_pkg::OFS_IMR, r & ~q & 32'h3FF, '1);
      bus(1'b1, 1'b0, sdr_pkg::OFS_IDR, 32'h3FF);
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         bus(1'b1, 1'b0, sdr_pkg::OFS_CSR0 + 8'(4 * i), r);
         rd(sdr_pkg::OFS_CSR0 + 8'(4 * i), r, '1);
         bus(1'b1, 1'b0, sdr_pkg::OFS_CSR0 + 8'(4 * i),
             (i == 0) ? 32'h0000_0108 : (i == 3) ? 32'h0000_0180 : 32'h0000_0100);
      end
      bus(1'b1, 1'b0, sdr_pkg::OFS_CTRL, 32'h1);
      nop(2);
      rd(sdr_pkg::OFS_SR, 32'h0001_0002, 32'h0001_0007);
      bus(1'b1, 1'b0, sdr_pkg::OFS_MODE, 32'h3);
      send(4'h0, 1'b0, 4'hE);
      chk(32'(lines), 32'hE);
      rd(sdr_pkg::OFS_RDR, {12'h000, 4'hE, 8'h00, ch[7:0]}, '1);
      for (int k = 0; k < 4; k++) begin
         eb = (k == 3) ? 5'h10 : 5'h08;
         send(sel_tab[k], 1'b1, line_tab[k]);
         chk(32'(lines), 32'hF);
         rd(sdr_pkg::OFS_RDR, {12'h000, line_tab[k], ((k == 3) ? ch : {8'h00, ch[7:0]})}, '1);
         rd(sdr_pkg::OFS_SR, 32'h0, 32'h9);
      end
      bus(1'b1, 1'b0, sdr_pkg::OFS_MODE, 32'h7);
      q = 32'($random(seed)) & 32'hF;
      eb = (q[3:2] == 2'h3) ? 5'h10 : 5'h08;
      send(q[3:0], 1'b1, q[3:0]);
      // Fixed select A uses the holding config, so an honoured final bit would show as a release.
      eb = 5'h08;
      bus(1'b1, 1'b0, sdr_pkg::OFS_MODE, 32'h000A_0001);
      send(4'hB, 1'b1, 4'hE);
      chk(32'(lines), 32'hE);
      bus(1'b1, 1'b0, sdr_pkg::OFS_MODE, 32'h000A_0000);
      slow = 1'b1;
      send(4'h0, 1'b0, 4'hE);
      chk(32'(master_o), 32'h0);
      rd(sdr_pkg::OFS_SR, 32'h9, 32'h9);
      rd(sdr_pkg::OFS_SR, 32'h0, 32'h8);
      rd(sdr_pkg::OFS_RDR, {16'h0000, 8'h00, ch[7:0]}, '1);
      bus(1'b1, 1'b0, sdr_pkg::OFS_IER, 32'h4);
      nop(1);
      MODE_FAULT_I <= 1'b1;
      nop(1);
      MODE_FAULT_I <= 1'b0;
      SLAVE_SELECT_IN_I <= 1'b1;
      nop(6);
      chk(32'(irq), 32'h1);
      rd(sdr_pkg::OFS_SR, 32'h104, 32'h104);
      rd(sdr_pkg::OFS_SR, 32'h0, 32'h104);
      nop(3);
      chk(32'(irq), 32'h0);
      @(posedge CLK_I);
      dz <= 4'h0;
      dw <= 2'h3;
      @(posedge CLK_I) dw <= 2'h0;
      rd(sdr_pkg::OFS_SR, 32'h00, 32'hF0);
      dz <= 4'h5;
      nop(1);
      rd(sdr_pkg::OFS_SR, 32'h30, 32'hF0);
      dz <= 4'hF;
      nop(1);
      rd(sdr_pkg::OFS_SR, 32'hF0, 32'hF0);
      bus(1'b1, 1'b0, sdr_pkg::OFS_CTRL, 32'h3);
      nop(1);
      rd(sdr_pkg::OFS_SR, 32'h0, 32'h0001_0202);
      nop(3);
      chk(32'(rq.size() + tq.size()), 32'h0);
      tally_and_finish;
   end
endmodule
